// ---- hdl/ccsow_pkg.sv ----
package ccsow_pkg;

  // clock configuration codes latched from the pins in the first clock after reset releases
  localparam logic [2:0] CFG_PRESCALE = 3'h1;
  localparam logic [2:0] CFG_DIRECT = 3'h3;
  localparam logic [2:0] CFG_X4 = 3'h7;
  localparam logic [2:0] CFG_X3 = 3'h6;
  localparam logic [2:0] CFG_X2 = 3'h5;
  localparam logic [2:0] CFG_X5 = 3'h4;
  localparam logic [2:0] CFG_X1P5 = 3'h2;
  localparam logic [2:0] CFG_X2P5 = 3'h0;
  localparam logic [2:0] CFG_RESET_VALUE = 3'h7;

  // system configuration register field
  localparam int SYSCFG_WIDTH = 16;
  localparam int OWD_DISABLE_BIT = 4;
  localparam logic [SYSCFG_WIDTH-1:0] SYSCFG_RESET = 16'h0000;

  // watchdog overflow after this many free-running ticks (half periods)
  localparam logic [4:0] OWD_OVERFLOW_COUNT = 5'h10;

  // free-running oscillator half period in system clocks
  localparam logic [3:0] FREE_HALF_DEFAULT = 4'h2;

  // pll factors expressed in half-steps (factor x 2)
  localparam logic [3:0] HALF_X4 = 4'h8;
  localparam logic [3:0] HALF_X3 = 4'h6;
  localparam logic [3:0] HALF_X2 = 4'h4;
  localparam logic [3:0] HALF_X5 = 4'ha;
  localparam logic [3:0] HALF_X1P5 = 4'h3;
  localparam logic [3:0] HALF_X2P5 = 4'h5;

  typedef enum logic [1:0] {
    CCSOW_SRC_PRESCALE,
    CCSOW_SRC_DIRECT,
    CCSOW_SRC_PLL,
    CCSOW_SRC_FREE
  } ccsow_src_t;

  // factor x 2 for a pll code; non-pll codes return zero
  function automatic logic [3:0] ccsow_half_factor(input logic [2:0] code);
    case (code)
      CFG_X4: ccsow_half_factor = HALF_X4;
      CFG_X3: ccsow_half_factor = HALF_X3;
      CFG_X2: ccsow_half_factor = HALF_X2;
      CFG_X5: ccsow_half_factor = HALF_X5;
      CFG_X1P5: ccsow_half_factor = HALF_X1P5;
      CFG_X2P5: ccsow_half_factor = HALF_X2P5;
      default: ccsow_half_factor = 4'h0;
    endcase
  endfunction

endpackage

// ---- hdl/ccsow_free_osc.sv ----
`timescale 1ns/10ps
// free-running oscillator model: a tick enable every half_period clocks while enabled
module ccsow_free_osc
  import ccsow_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [3:0] half_period,
  // output
  output logic tick,
  output logic level
);

  logic [3:0] cnt_reg;

  // divider; stopped and parked low when powered off
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
      level <= 1'b0;
    end else if (cnt_reg + 4'h1 >= half_period) begin
      cnt_reg <= 4'h0;
      tick <= 1'b1;
      level <= ~level;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      tick <= 1'b0;
    end
  end

endmodule

// ---- hdl/ccsow_watchdog.sv ----
`timescale 1ns/10ps
// oscillator watchdog counter: cleared by input edges, counts free-running ticks
module ccsow_watchdog
  import ccsow_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic osc_edge,
  input wire logic free_tick,
  // status
  output logic overflow
);

  logic [4:0] count_reg;

  // each oscillator transition clears, each free-running tick counts
  always_ff @(posedge clk) begin
    if (rst || !enable || osc_edge) begin
      count_reg <= 5'h00;
    end else if (free_tick && count_reg != OWD_OVERFLOW_COUNT) begin
      count_reg <= count_reg + 5'h01;
    end
  end

  // overflow once sixteen ticks pass without a transition
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= enable && !osc_edge && free_tick
        && (count_reg + 5'h01 == OWD_OVERFLOW_COUNT);
    end
  end

endmodule

// ---- hdl/ccsow_top.sv ----
`timescale 1ns/10ps
// Behaviour
// - code 001 divides oscillator input by two
// - prescaled phases each last one input period
// - code 011 drives cpu clock directly
// - other codes use pll multiplication
// - codes map to factors 4,3,2,5,1.5,2.5
// - pll resyncs every 2F-th input rising edge (4F transitions)
// - watchdog enabled after reset; bit 4 disables
// - free-running ticks count; input edges clear
// - overflow after sixteen free-running ticks (eight cycles)
// - overflow switches to free clock, raises flag
// - free clock kept until hardware reset
// - direct modes: pll free-runs unless watchdog disabled
// - direct modes, watchdog disabled: external clock, pll off
module ccsow_top
  import ccsow_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator input pin and configuration straps
  input wire logic oscillator_input_pin,
  input wire logic [2:0] clock_config_pins,
  // system configuration register write port
  input wire logic sys_cfg_we,
  input wire logic [SYSCFG_WIDTH-1:0] sys_cfg_wdata,
  // free-running oscillator speed
  input wire logic [3:0] free_half_period,
  // clock outputs and status
  output logic cpu_clk,
  output logic cpu_clk_tick,
  output logic [2:0] boot_clock_select_bits,
  output logic [SYSCFG_WIDTH-1:0] system_config_register,
  output logic osc_watchdog_disable,
  output logic pll_on,
  output logic clock_failed,
  output logic osc_fail_interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection

  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic [2:0] cfg_s1_reg;
  logic [2:0] cfg_s2_reg;
  logic osc_edge;
  logic osc_rise;
  logic in_reset_reg;

  // two flops before use; third stage only feeds edge detection
  always_ff @(posedge clk) begin
    osc_s1_reg <= oscillator_input_pin;
    osc_s2_reg <= osc_s1_reg;
    osc_s3_reg <= osc_s2_reg;
    cfg_s1_reg <= clock_config_pins;
    cfg_s2_reg <= cfg_s1_reg;
  end

  // both edges clear the watchdog and tick the direct clock; rising edges pace the prescaler and pll
  assign osc_edge = osc_s2_reg ^ osc_s3_reg;
  assign osc_rise = osc_s2_reg & ~osc_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // strap capture

  // straps taken in the first clock after reset releases, then frozen
  always_ff @(posedge clk) begin
    if (rst) begin
      in_reset_reg <= 1'b1;
      boot_clock_select_bits <= CFG_RESET_VALUE;
    end else if (in_reset_reg) begin
      in_reset_reg <= 1'b0;
      boot_clock_select_bits <= cfg_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system configuration register

  // watchdog enabled by default; software sets bit 4 to disable
  always_ff @(posedge clk) begin
    if (rst) begin
      system_config_register <= SYSCFG_RESET;
    end else if (sys_cfg_we) begin
      system_config_register <= sys_cfg_wdata;
    end
  end

  logic owd_dis;
  // internal logic reads the register bit, a cycle ahead of the status port
  assign owd_dis = system_config_register[OWD_DISABLE_BIT];

  // status copy of the disable bit, one cycle behind the register
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_watchdog_disable <= 1'b0;
    end else begin
      osc_watchdog_disable <= owd_dis;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  logic direct_mode;
  logic prescale_mode;
  logic pll_mode;
  logic [3:0] half_factor;

  // modes stay off in the capture cycle, so no clock starts from the reset
  // default code before the real straps are in
  assign prescale_mode = !in_reset_reg && boot_clock_select_bits == CFG_PRESCALE;
  assign direct_mode = !in_reset_reg && boot_clock_select_bits == CFG_DIRECT;
  assign pll_mode = !in_reset_reg && !prescale_mode && !direct_mode;
  assign half_factor = ccsow_half_factor(boot_clock_select_bits);

  ////////////////////////////////////////////////////////////////////////
  // free-running oscillator and watchdog

  logic free_run;
  logic free_tick;
  logic free_level;
  logic wd_overflow;
  logic failed_reg;
  logic [3:0] free_half;

  // pll runs in pll mode, or free-running for the watchdog unless disabled;
  // once failed it must keep running as the cpu source
  assign free_run = !in_reset_reg && (pll_mode || !owd_dis || failed_reg);
  assign free_half = (free_half_period == 4'h0) ? FREE_HALF_DEFAULT : free_half_period;

  // the free oscillator stands in for the pll running open loop; its speed
  // is a port so a slow or fast free-running pll can be modelled
  ccsow_free_osc u_free_osc (
    .clk(clk),
    .rst(rst),
    .run(free_run),
    .half_period(free_half),
    .tick(free_tick),
    .level(free_level)
  );

  // watchdog guards the direct and prescaled crystal modes only
  ccsow_watchdog u_watchdog (
    .clk(clk),
    .rst(rst),
    .enable(!owd_dis && (direct_mode || prescale_mode) && !failed_reg),
    .osc_edge(osc_edge),
    .free_tick(free_tick),
    .overflow(wd_overflow)
  );

  // failure latch only clears on hardware reset
  always_ff @(posedge clk) begin
    if (rst) begin
      failed_reg <= 1'b0;
    end else if (wd_overflow) begin
      failed_reg <= 1'b1;
    end
  end

  // interrupt flag has no software clear here; only a hardware reset drops it
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_fail_interrupt <= 1'b0;
    end else if (wd_overflow) begin
      osc_fail_interrupt <= 1'b1;
    end
  end

  // status outputs are registered copies so every port comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_failed <= 1'b0;
      pll_on <= 1'b0;
    end else begin
      clock_failed <= failed_reg || wd_overflow;
      pll_on <= free_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pll model: edge budget per resync window, spread evenly

  // a window is half_factor input rising edges (4F transitions, a whole
  // multiple of F also for the 1.5 and 2.5 codes); it carries half_factor
  // squared cpu edges, so the cpu clock runs at F times the input
  logic [6:0] pll_budget_reg;
  logic [3:0] pll_edge_cnt_reg;
  logic [3:0] pll_gap_reg;
  logic [3:0] pll_spacing_reg;
  logic [7:0] pll_period_reg;
  logic [7:0] pll_span;
  logic [7:0] pll_window_edges;
  logic pll_step;

  // locked when one input period spans spacing*half_factor clocks; a window
  // holds at most 100 edges, so the budget fits in seven bits
  assign pll_span = 8'(pll_spacing_reg) * 8'(half_factor);
  assign pll_window_edges = 8'(half_factor) * 8'(half_factor);

  // measure the input period in clocks; saturates on very slow inputs
  always_ff @(posedge clk) begin
    if (rst || !pll_mode) begin
      pll_period_reg <= 8'h00;
      pll_spacing_reg <= 4'h1;
    end else if (osc_rise) begin
      pll_period_reg <= 8'h01;
      // spacing moves one clock per input edge, so frequency never jumps
      if (pll_period_reg >= pll_span + 8'(half_factor) && pll_spacing_reg != 4'hf) begin
        pll_spacing_reg <= pll_spacing_reg + 4'h1;
      end else if (pll_period_reg < pll_span && pll_spacing_reg != 4'h1) begin
        pll_spacing_reg <= pll_spacing_reg - 4'h1;
      end
    end else if (pll_period_reg != 8'hff) begin
      pll_period_reg <= pll_period_reg + 8'h01;
    end
  end

  assign pll_step = pll_mode && pll_budget_reg != 7'h00 && pll_gap_reg == 4'h0;

  // reload the edge budget at the start of every window
  always_ff @(posedge clk) begin
    if (rst || !pll_mode) begin
      pll_budget_reg <= 7'h00;
      pll_edge_cnt_reg <= 4'h0;
      pll_gap_reg <= 4'h0;
    end else begin
      if (osc_rise && pll_edge_cnt_reg == 4'h0) begin
        // leftovers are dropped so each window restarts in phase with the input
        pll_budget_reg <= pll_window_edges[6:0];
        pll_edge_cnt_reg <= 4'h1;
      end else begin
        if (osc_rise) begin
          pll_edge_cnt_reg <= (pll_edge_cnt_reg + 4'h1 >= half_factor) ? 4'h0
                              : pll_edge_cnt_reg + 4'h1;
        end
        if (pll_step) begin
          pll_budget_reg <= pll_budget_reg - 7'h01;
        end
      end
      pll_gap_reg <= pll_step ? (pll_spacing_reg - 4'h1)
                     : (pll_gap_reg != 4'h0 ? pll_gap_reg - 4'h1 : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu clock selection

  ccsow_src_t src;

  // failure overrides all; disabled watchdog keeps the crystal source
  always_comb begin
    if (failed_reg) begin
      src = CCSOW_SRC_FREE;
    end else if (prescale_mode) begin
      src = CCSOW_SRC_PRESCALE;
    end else if (direct_mode) begin
      src = CCSOW_SRC_DIRECT;
    end else begin
      src = CCSOW_SRC_PLL;
    end
  end

  // prescaler toggles on each input rising edge: each phase lasts one
  // input period regardless of duty cycle
  always_ff @(posedge clk) begin
    if (rst || in_reset_reg) begin
      cpu_clk <= 1'b0;
      cpu_clk_tick <= 1'b0;
    end else begin
      case (src)
        CCSOW_SRC_PRESCALE: begin
          cpu_clk_tick <= osc_rise;
          if (osc_rise) begin
            cpu_clk <= ~cpu_clk;
          end
        end
        CCSOW_SRC_DIRECT: begin
          cpu_clk_tick <= osc_edge;
          cpu_clk <= osc_s2_reg;
        end
        CCSOW_SRC_PLL: begin
          cpu_clk_tick <= pll_step;
          if (pll_step) begin
            cpu_clk <= ~cpu_clk;
          end
        end
        CCSOW_SRC_FREE: begin
          cpu_clk_tick <= free_tick;
          cpu_clk <= free_level;
        end
        default: begin
          cpu_clk_tick <= 1'b0;
          cpu_clk <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- tb/ccsow_checker.sv ----
`timescale 1ns/10ps
module ccsow_checker
  import ccsow_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stimulus
  input wire logic oscillator_input_pin,
  input wire logic sys_cfg_we,
  input wire logic [SYSCFG_WIDTH-1:0] sys_cfg_wdata,
  input wire logic [3:0] free_half_period,
  // results
  input wire logic [2:0] boot_clock_select_bits,
  input wire logic [SYSCFG_WIDTH-1:0] system_config_register,
  input wire logic osc_watchdog_disable,
  input wire logic pll_on,
  input wire logic clock_failed,
  input wire logic osc_fail_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int quiet;
  int hp;
  logic pin_q;
  logic direct;
  // cycles since the pin last moved; overflow may not come sooner
  always_ff @(posedge clk) begin
    pin_q <= oscillator_input_pin;
    quiet <= (rst || pin_q != oscillator_input_pin) ? 0 : quiet + 1;
  end
  // zero speed is read as two, as the design does
  assign hp = (free_half_period == 4'h0) ? 2 : int'(free_half_period);
  assign direct = boot_clock_select_bits inside {CFG_DIRECT, CFG_PRESCALE};
  //////////////////////////////////////////////////////////////
  sequence s_write;
    sys_cfg_we;
  endsequence
  property p_reg_write;
    s_write |=> system_config_register == $past(sys_cfg_wdata);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("register write lost");
  property p_disable_bit;
    s_write |-> ##2 osc_watchdog_disable == $past(sys_cfg_wdata[OWD_DISABLE_BIT], 2);
  endproperty
  a_disable_bit: assert property (p_disable_bit) else $error("disable bit wrong");
  property p_straps_hold;
    !$past(rst) && !$past(rst, 2) |-> $stable(boot_clock_select_bits);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("straps moved");
  property p_fail_sticky;
    clock_failed |=> clock_failed && osc_fail_interrupt;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure not kept");
  property p_irq_with_fail;
    $rose(clock_failed) |-> osc_fail_interrupt;
  endproperty
  a_irq_with_fail: assert property (p_irq_with_fail) else $error("no fail flag");
  property p_fail_quiet;
    $rose(clock_failed) |-> quiet >= 16 * hp;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet) else $error("overflow too early");
  property p_pll_off;
    direct && !clock_failed && osc_watchdog_disable && $past(osc_watchdog_disable)
      && $past(osc_watchdog_disable, 2) |-> !pll_on;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll left running");
  property p_pll_free;
    direct && !osc_watchdog_disable && !system_config_register[OWD_DISABLE_BIT]
      && !$past(rst) |-> ##[0:3] pll_on;
  endproperty
  a_pll_free: assert property (p_pll_free) else $error("pll not free running");
  property p_no_fail_pll;
    !direct && !$past(rst) && !$past(rst, 2) |-> !clock_failed;
  endproperty
  a_no_fail_pll: assert property (p_no_fail_pll) else $error("failure in pll mode");
endmodule
bind ccsow_top ccsow_checker u_chk (.clk, .rst, .oscillator_input_pin, .sys_cfg_we,
  .sys_cfg_wdata, .free_half_period, .boot_clock_select_bits, .system_config_register,
  .osc_watchdog_disable, .pll_on, .clock_failed, .osc_fail_interrupt);

// ---- tb/ccsow_osc_model.sv ----
`timescale 1ns/10ps
// external clock source; a stopped source freezes at its level, like a dead crystal
module ccsow_osc_model (
  // control
  input wire logic run,
  input wire logic [31:0] half_ns,
  // pin
  output logic osc
);
  initial osc = 1'b0;
  // toggle each half period while running
  always begin
    if (run) #(half_ns) osc = ~osc;
    else #50;
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import ccsow_pkg::*;
();
  logic clk, rst, run, we, cpu_clk, tick, osc, wd_off, pll_on, failed, irq;
  logic [2:0] pins, boot;
  logic [15:0] wdata, sreg;
  logic [3:0] free_hp;
  int half_ns, n_errors, n_compared, n;
  ccsow_osc_model xo (.run(run), .half_ns(half_ns), .osc(osc));
  ccsow_top dut (.clk(clk), .rst(rst), .oscillator_input_pin(osc),
    .clock_config_pins(pins), .sys_cfg_we(we), .sys_cfg_wdata(wdata),
    .free_half_period(free_hp), .cpu_clk(cpu_clk), .cpu_clk_tick(tick),
    .boot_clock_select_bits(boot), .system_config_register(sreg),
    .osc_watchdog_disable(wd_off), .pll_on(pll_on), .clock_failed(failed),
    .osc_fail_interrupt(irq));
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_in(input string what, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // reset for five cycles with the given straps, then move the straps away
  task boot_with(input logic [2:0] c);
    @(negedge clk);
    rst = 1'b1;
    pins = c;
    cyc(1);
    chk("straps in reset", 16'h7, 16'(boot));
    cyc(4);
    rst = 1'b0;
    cyc(3);
    chk("straps", 16'(c), 16'(boot));
    pins = ~c;
    cyc(4);
    chk("straps held", 16'(c), 16'(boot));
  endtask
  // length of the next high phase of the cpu clock, bounded
  task phase(output int len);
    int k;
    k = 0;
    len = 0;
    while (cpu_clk !== 1'b0 && k < 400) begin cyc(1); k++; end
    while (cpu_clk !== 1'b1 && k < 400) begin cyc(1); k++; end
    while (cpu_clk === 1'b1 && k < 400) begin cyc(1); k++; len++; end
  endtask
  task wr(input logic [15:0] d);
    wdata = d;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(3);
  endtask
  //////////////////////////////////////////////////////////////
  task t_prescale;
    boot_with(CFG_PRESCALE);
    cyc(20);
    phase(n);
    chk_in("prescale high phase", 8, 8, n);
    chk("pll free", 16'h1, 16'(pll_on));
    wr(16'h0010);
    chk("register", 16'h0010, sreg);
    chk("pll stopped", 16'h0, 16'(pll_on));
  endtask
  task t_watchdog;
    boot_with(CFG_DIRECT);
    chk("watchdog on", 16'h0, 16'(wd_off));
    cyc(10);
    phase(n);
    chk_in("direct high phase", 4, 4, n);
    run = 1'b0;
    n = 0;
    while (failed !== 1'b1 && n < 200) begin cyc(1); n++; end
    chk_in("overflow delay", 32, 44, n);
    chk("fail flag", 16'h1, 16'(irq));
    run = 1'b1;
    cyc(50);
    chk("still failed", 16'h1, 16'(failed));
    phase(n);
    chk_in("free high phase", 2, 2, n);
    boot_with(CFG_DIRECT);
    chk("failure cleared", 16'h0, 16'(failed));
    phase(n);
    chk_in("direct again", 4, 4, n);
  endtask
  task t_wd_off;
    wr(16'h0010);
    chk("watchdog off", 16'h1, 16'(wd_off));
    run = 1'b0;
    cyc(100);
    chk("no failure", 16'h0, 16'(failed));
    chk("pll off", 16'h0, 16'(pll_on));
    run = 1'b1;
  endtask
  // each pll code: clock edges per input period equal twice the factor
  task t_pll;
    logic [2:0] c [6];
    int h [6];
    c = '{CFG_X4, CFG_X3, CFG_X2, CFG_X5, CFG_X1P5, CFG_X2P5};
    h = '{8, 6, 4, 10, 3, 5};
    half_ns = 1000;
    for (int i = 0; i < 6; i++) begin
      boot_with(c[i]);
      cyc(800);
      n = 0;
      repeat (320) begin cyc(1); n += (tick === 1'b1); end
      chk_in("pll edges", 7 * h[i], 9 * h[i], n);
      chk("pll no failure", 16'h0, 16'(failed));
    end
  endtask
  //////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    run = 1'b1;
    half_ns = 200;
    pins = 3'h7;
    we = 1'b0;
    wdata = 16'h0000;
    free_hp = 4'h2;
    n_errors = 0;
    n_compared = 0;
    t_prescale;
    t_watchdog;
    t_wd_off;
    t_pll;
    print_verdict;
  end
  // hang guard, about three times the expected run
  initial begin
    #1ms;
    n_errors++;
    print_verdict;
  end
endmodule
